// [logic/bff_pkg.sv]
// Shared constants, types and helpers of the bidirectional FIFO block
`default_nettype none
package bff_pkg;
    localparam int BFF_DATA_W      = 36;
    localparam int BFF_DEPTH       = 256;
    localparam int BFF_PTR_W       = 8;
    localparam int BFF_CNT_W       = 9;
    localparam int BFF_HALF_W      = 18;
    localparam int BFF_BYTE_W      = 9;
    localparam int BFF_SYNC_STAGES = 2;
    localparam int BFF_PORTS       = 2;
    localparam int BFF_FLAGS       = 4;

    localparam logic [BFF_CNT_W-1:0] BFF_DEPTH_CNT = 9'h100;
    localparam logic [BFF_CNT_W-1:0] BFF_OFFSET_8  = 9'h008;
    localparam logic [BFF_CNT_W-1:0] BFF_OFFSET_16 = 9'h010;
    localparam logic [BFF_CNT_W-1:0] BFF_OFFSET_64 = 9'h040;

    // Register map, byte addresses
    localparam int              BFF_ADDR_W        = 5;
    localparam logic [4:0]      BFF_REG_CONFIG    = 5'h00;
    localparam logic [4:0]      BFF_REG_OFFSET_AE = 5'h04;
    localparam logic [4:0]      BFF_REG_OFFSET_AF = 5'h08;
    localparam logic [4:0]      BFF_REG_STATUS    = 5'h0c;
    localparam logic [4:0]      BFF_REG_MASK      = 5'h10;
    localparam logic [4:0]      BFF_REG_COUNT     = 5'h14;
    localparam int              BFF_OFS_A_LSB     = 0;
    localparam int              BFF_OFS_B_LSB     = 16;

    // Event bits of status and mask
    localparam int              BFF_EV_N          = 6;
    localparam int              BFF_EV_A_WR_DROP  = 0;
    localparam int              BFF_EV_B_WR_DROP  = 1;
    localparam int              BFF_EV_A_RD_EMPTY = 2;
    localparam int              BFF_EV_B_RD_EMPTY = 3;
    localparam int              BFF_EV_AB_AFULL   = 4;
    localparam int              BFF_EV_BA_AFULL   = 5;
    localparam logic [5:0]      BFF_MASK_RESET    = 6'h00;

    // Flag vector order and levels after reset (active low flags)
    localparam int              BFF_FLAG_AE_A     = 0;
    localparam int              BFF_FLAG_AE_B     = 1;
    localparam int              BFF_FLAG_AF_A     = 2;
    localparam int              BFF_FLAG_AF_B     = 3;
    localparam logic [3:0]      BFF_FLAG_RESET    = 4'hc;

    typedef enum logic [1:0] {BFF_LONG, BFF_WORD, BFF_BYTE} bff_width_t;

    typedef struct packed {
        logic       big_endian;
        logic       standard_timing;
        bff_width_t width;
    } bff_mode_t;

    typedef struct packed {
        logic [BFF_CNT_W-1:0] ae_a;
        logic [BFF_CNT_W-1:0] ae_b;
        logic [BFF_CNT_W-1:0] af_a;
        logic [BFF_CNT_W-1:0] af_b;
    } bff_offsets_t;

    function automatic logic [1:0] bff_last_piece(input bff_width_t w);
        case (w)
            BFF_WORD: return 2'h1;
            BFF_BYTE: return 2'h3;
            default:  return 2'h0;
        endcase
    endfunction

    function automatic logic [1:0] bff_phys(input bff_width_t w, input logic big, input logic [1:0] idx);
        return big ? 2'(bff_last_piece(w) - idx) : idx;
    endfunction

    function automatic logic [35:0] bff_piece_get(input logic [35:0] word, input bff_width_t w,
                                                  input logic big, input logic [1:0] idx);
        logic [1:0] p;
        p = bff_phys(w, big, idx);
        case (w)
            BFF_WORD: return {18'h0, word[18*p +: 18]};
            BFF_BYTE: return {27'h0, word[9*p +: 9]};
            default:  return word;
        endcase
    endfunction

    function automatic logic [35:0] bff_piece_put(input logic [35:0] word, input logic [35:0] piece,
                                                  input bff_width_t w, input logic big, input logic [1:0] idx);
        logic [1:0]  p;
        logic [35:0] r;
        p = bff_phys(w, big, idx);
        r = word;
        case (w)
            BFF_WORD: r[18*p +: 18] = piece[17:0];
            BFF_BYTE: r[9*p +: 9] = piece[8:0];
            default:  r = piece;
        endcase
        return r;
    endfunction
endpackage
`default_nettype wire

// [logic/bff_fifo.sv]
// One direction of storage: flip-flop array with word count
`default_nettype none
module bff_fifo (
    input  wire logic                           clk_in,
    input  wire logic                           rst_in,
    input  wire logic                           push_in,
    input  wire logic [bff_pkg::BFF_DATA_W-1:0] push_data_in,
    input  wire logic                           pop_in,
    output logic      [bff_pkg::BFF_DATA_W-1:0] head_out,
    output logic      [bff_pkg::BFF_CNT_W-1:0]  count_out,
    output logic                                full_out,
    output logic                                empty_out
);
    import bff_pkg::*;

    logic [BFF_DATA_W-1:0] mem [BFF_DEPTH];
    logic [BFF_PTR_W-1:0]  wr_ptr;
    logic [BFF_PTR_W-1:0]  rd_ptr;
    logic                  push_ok;
    logic                  pop_ok;

    assign full_out  = (count_out == BFF_DEPTH_CNT);
    assign empty_out = (count_out == '0);
    assign push_ok   = push_in && !full_out;
    assign pop_ok    = pop_in && !empty_out;
    assign head_out  = mem[rd_ptr];

    // Storage has no reset; only pointers define content
    always_ff @(posedge clk_in) begin
        if (push_ok) begin
            mem[wr_ptr] <= push_data_in;
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            wr_ptr    <= '0;
            rd_ptr    <= '0;
            count_out <= '0;
        end else begin
            if (push_ok) begin
                wr_ptr <= wr_ptr + 8'h01;
            end
            if (pop_ok) begin
                rd_ptr <= rd_ptr + 8'h01;
            end
            count_out <= count_out + 9'(push_ok) - 9'(pop_ok);
        end
    end
endmodule
`default_nettype wire

// [logic/bff_flag_sync.sv]
// Two-stage pipeline that carries one threshold flag to its port
`default_nettype none
module bff_flag_sync #(
    parameter logic RESET_VAL = 1'b1
) (
    input  wire logic clk_in,
    input  wire logic rst_in,
    input  wire logic level_in,
    output logic      flag_out
);
    import bff_pkg::*;

    logic [BFF_SYNC_STAGES-1:0] chain;

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            chain <= {BFF_SYNC_STAGES{RESET_VAL}};
        end else begin
            chain <= {chain[BFF_SYNC_STAGES-2:0], level_in};
        end
    end

    assign flag_out = chain[BFF_SYNC_STAGES-1];
endmodule
`default_nettype wire

// [logic/bff_top.sv]
// Bidirectional dual FIFO with threshold flags, bus matching and mode select
`default_nettype none
module bff_top (
    input  wire logic                             clk_in,
    input  wire logic                             rst_in,
    input  wire logic                             endian_timing_select_in,
    input  wire logic                             port_b_bus_match_select_in,
    input  wire logic                             port_b_size_select_in,
    input  wire logic                             flag_offset_select_0_in,
    input  wire logic                             flag_offset_select_1_in,
    input  wire logic [bff_pkg::BFF_DATA_W-1:0]   port_a_data_bus_in,
    output logic      [bff_pkg::BFF_DATA_W-1:0]   port_a_data_bus_out,
    output logic                                  port_a_data_bus_oe_out,
    input  wire logic                             port_a_output_enable_in,
    input  wire logic                             port_a_write_in,
    input  wire logic                             port_a_read_in,
    output logic                                  port_a_valid_out,
    input  wire logic [bff_pkg::BFF_DATA_W-1:0]   port_b_data_bus_in,
    output logic      [bff_pkg::BFF_DATA_W-1:0]   port_b_data_bus_out,
    output logic                                  port_b_data_bus_oe_out,
    input  wire logic                             port_b_output_enable_in,
    input  wire logic                             port_b_write_in,
    input  wire logic                             port_b_read_in,
    output logic                                  port_b_valid_out,
    output logic                                  port_a_almost_empty_flag_n_out,
    output logic                                  port_b_almost_empty_flag_n_out,
    output logic                                  port_a_almost_full_flag_n_out,
    output logic                                  port_b_almost_full_flag_n_out,
    input  wire logic [bff_pkg::BFF_ADDR_W-1:0]   reg_addr_in,
    input  wire logic [31:0]                      reg_wdata_in,
    input  wire logic                             reg_write_in,
    input  wire logic                             reg_read_in,
    output logic      [31:0]                      reg_rdata_out,
    output logic                                  irq_out
);
    import bff_pkg::*;

    // Endian and default offsets captured once after master reset; bus width and timing follow the pins
    logic                   cfg_loaded;
    logic                   big_endian;
    bff_width_t             b_width;
    bff_mode_t              mode_a;
    bff_mode_t              mode_b;
    bff_offsets_t           offsets;
    logic [BFF_CNT_W-1:0]   default_offset;

    logic                   ab_push;
    logic [BFF_DATA_W-1:0]  ab_head;
    logic [BFF_CNT_W-1:0]   ab_count;
    logic                   ab_full;
    logic                   ab_empty;
    logic                   ba_push;
    logic [BFF_DATA_W-1:0]  ba_head;
    logic [BFF_CNT_W-1:0]   ba_count;
    logic                   ba_full;
    logic                   ba_empty;

    logic [BFF_DATA_W-1:0]  b_asm;
    logic [1:0]             b_wr_piece;
    logic                   b_wr_last;
    logic [BFF_DATA_W-1:0]  next_b_asm;

    // Read side per port: index 0 is port A, index 1 is port B
    bff_mode_t              rd_mode     [BFF_PORTS];
    logic [BFF_DATA_W-1:0]  rd_head     [BFF_PORTS];
    logic                   rd_empty    [BFF_PORTS];
    logic                   rd_req      [BFF_PORTS];
    logic                   rd_pop      [BFF_PORTS];
    logic                   rd_valid    [BFF_PORTS];
    logic                   rd_underrun [BFF_PORTS];
    logic [BFF_DATA_W-1:0]  rd_data     [BFF_PORTS];

    logic [BFF_CNT_W-1:0]   flag_level  [BFF_FLAGS];
    logic [BFF_CNT_W-1:0]   flag_offset [BFF_FLAGS];
    logic [BFF_FLAGS-1:0]   flag_n;
    logic [BFF_FLAGS-1:0]   flag_n_prev;

    logic [BFF_EV_N-1:0]    status;
    logic [BFF_EV_N-1:0]    mask;
    logic [BFF_EV_N-1:0]    events;
    logic                   status_clear;

    always_comb begin
        case ({flag_offset_select_1_in, flag_offset_select_0_in})
            2'b01:   default_offset = BFF_OFFSET_16;
            2'b10:   default_offset = BFF_OFFSET_64;
            default: default_offset = BFF_OFFSET_8;
        endcase
    end

    // Endian level and default thresholds are caught at the first edge after release
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            cfg_loaded <= 1'b0;
            big_endian <= 1'b0;
        end else if (!cfg_loaded) begin
            cfg_loaded <= 1'b1;
            big_endian <= endian_timing_select_in;
        end
    end

    always_comb begin
        if (!port_b_bus_match_select_in) begin
            b_width = BFF_LONG;
        end else if (port_b_size_select_in) begin
            b_width = BFF_BYTE;
        end else begin
            b_width = BFF_WORD;
        end
    end

    // Pin is read live after reset; the far side must keep it and bus-match static
    assign mode_b = '{big_endian: big_endian,
                      standard_timing: endian_timing_select_in,
                      width: b_width};
    assign mode_a = '{big_endian: big_endian,
                      standard_timing: endian_timing_select_in,
                      width: BFF_LONG};

    bff_fifo u_a_to_b_fifo (
        .clk_in       (clk_in),
        .rst_in       (rst_in),
        .push_in      (ab_push),
        .push_data_in (port_a_data_bus_in),
        .pop_in       (rd_pop[1]),
        .head_out     (ab_head),
        .count_out    (ab_count),
        .full_out     (ab_full),
        .empty_out    (ab_empty)
    );

    bff_fifo u_b_to_a_fifo (
        .clk_in       (clk_in),
        .rst_in       (rst_in),
        .push_in      (ba_push),
        .push_data_in (next_b_asm),
        .pop_in       (rd_pop[0]),
        .head_out     (ba_head),
        .count_out    (ba_count),
        .full_out     (ba_full),
        .empty_out    (ba_empty)
    );

    // Port A writes whole long words
    assign ab_push = port_a_write_in && cfg_loaded && !ab_full;

    // Port B pieces fill a long word in endian order; a full FIFO drops the whole word
    assign b_wr_last  = (b_wr_piece == bff_last_piece(b_width));
    assign next_b_asm = bff_piece_put(b_asm, port_b_data_bus_in, b_width, big_endian, b_wr_piece);
    assign ba_push    = port_b_write_in && cfg_loaded && b_wr_last && !ba_full;

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            b_asm      <= '0;
            b_wr_piece <= 2'h0;
        end else if (port_b_write_in && cfg_loaded) begin
            b_asm      <= b_wr_last ? '0 : next_b_asm;
            b_wr_piece <= b_wr_last ? 2'h0 : 2'(b_wr_piece + 2'h1);
        end
    end

    assign rd_mode[0]  = mode_a;
    assign rd_mode[1]  = mode_b;
    assign rd_head[0]  = ba_head;
    assign rd_head[1]  = ab_head;
    assign rd_empty[0] = ba_empty;
    assign rd_empty[1] = ab_empty;
    assign rd_req[0]   = port_a_read_in && cfg_loaded;
    assign rd_req[1]   = port_b_read_in && cfg_loaded;

    for (genvar p = 0; p < BFF_PORTS; p++) begin : g_reader
        logic [BFF_DATA_W-1:0] hold;
        logic [1:0]            piece;
        logic                  last;
        logic [BFF_DATA_W-1:0] next_hold;
        logic [1:0]            next_piece;
        logic                  next_valid;
        logic                  fetch;

        assign last = (piece == bff_last_piece(rd_mode[p].width));

        always_comb begin
            next_hold  = hold;
            next_piece = piece;
            next_valid = rd_valid[p];
            fetch      = 1'b0;
            if (rd_mode[p].standard_timing) begin
                if (rd_req[p]) begin
                    if (rd_valid[p] && !last) begin
                        next_piece = 2'(piece + 2'h1);
                    end else begin
                        fetch = !rd_empty[p];
                    end
                end
            end else if (rd_valid[p] && rd_req[p] && !last) begin
                next_piece = 2'(piece + 2'h1);
            end else if (!rd_valid[p] || rd_req[p]) begin
                fetch = !rd_empty[p];
            end
            if (fetch) begin
                next_hold  = rd_head[p];
                next_piece = 2'h0;
                next_valid = 1'b1;
            end else if (next_piece == piece && rd_req[p]) begin
                next_valid = 1'b0;
            end
        end

        assign rd_pop[p]      = fetch;
        assign rd_underrun[p] = rd_req[p] && (rd_mode[p].standard_timing ? !next_valid : !rd_valid[p]);

        always_ff @(posedge clk_in or posedge rst_in) begin
            if (rst_in) begin
                hold        <= '0;
                piece       <= 2'h0;
                rd_valid[p] <= 1'b0;
                rd_data[p]  <= '0;
            end else begin
                hold        <= next_hold;
                piece       <= next_piece;
                rd_valid[p] <= next_valid;
                rd_data[p]  <= bff_piece_get(next_hold, rd_mode[p].width, rd_mode[p].big_endian,
                                             next_piece);
            end
        end
    end

    assign port_a_data_bus_out    = rd_data[0];
    assign port_b_data_bus_out    = rd_data[1];
    assign port_a_valid_out       = rd_valid[0];
    assign port_b_valid_out       = rd_valid[1];
    assign port_a_data_bus_oe_out = port_a_output_enable_in;
    assign port_b_data_bus_oe_out = port_b_output_enable_in;

    assign flag_level[BFF_FLAG_AE_A]  = ba_count;
    assign flag_offset[BFF_FLAG_AE_A] = offsets.ae_a;
    assign flag_level[BFF_FLAG_AE_B]  = ab_count;
    assign flag_offset[BFF_FLAG_AE_B] = offsets.ae_b;
    assign flag_level[BFF_FLAG_AF_A]  = 9'(BFF_DEPTH_CNT - ab_count);
    assign flag_offset[BFF_FLAG_AF_A] = offsets.af_a;
    assign flag_level[BFF_FLAG_AF_B]  = 9'(BFF_DEPTH_CNT - ba_count);
    assign flag_offset[BFF_FLAG_AF_B] = offsets.af_b;

    // Every flag sees the same two-edge delay, so edges line up across ports
    for (genvar f = 0; f < BFF_FLAGS; f++) begin : g_flag
        bff_flag_sync #(
            .RESET_VAL (BFF_FLAG_RESET[f])
        ) u_sync (
            .clk_in   (clk_in),
            .rst_in   (rst_in),
            .level_in (!(flag_level[f] <= flag_offset[f])),
            .flag_out (flag_n[f])
        );
    end

    assign port_a_almost_empty_flag_n_out = flag_n[BFF_FLAG_AE_A];
    assign port_b_almost_empty_flag_n_out = flag_n[BFF_FLAG_AE_B];
    assign port_a_almost_full_flag_n_out  = flag_n[BFF_FLAG_AF_A];
    assign port_b_almost_full_flag_n_out  = flag_n[BFF_FLAG_AF_B];

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            flag_n_prev <= BFF_FLAG_RESET;
        end else begin
            flag_n_prev <= flag_n;
        end
    end

    always_comb begin
        events                    = '0;
        events[BFF_EV_A_WR_DROP]  = port_a_write_in && cfg_loaded && ab_full;
        events[BFF_EV_B_WR_DROP]  = port_b_write_in && cfg_loaded && b_wr_last && ba_full;
        events[BFF_EV_A_RD_EMPTY] = rd_underrun[0];
        events[BFF_EV_B_RD_EMPTY] = rd_underrun[1];
        events[BFF_EV_AB_AFULL]   = flag_n_prev[BFF_FLAG_AF_A] && !flag_n[BFF_FLAG_AF_A];
        events[BFF_EV_BA_AFULL]   = flag_n_prev[BFF_FLAG_AF_B] && !flag_n[BFF_FLAG_AF_B];
    end

    // Thresholds: defaults loaded after reset, later overwritten by software
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            offsets <= '{BFF_OFFSET_8, BFF_OFFSET_8, BFF_OFFSET_8, BFF_OFFSET_8};
        end else if (!cfg_loaded) begin
            offsets <= '{default_offset, default_offset, default_offset, default_offset};
        end else if (reg_write_in && reg_addr_in == BFF_REG_OFFSET_AE) begin
            offsets.ae_a <= reg_wdata_in[BFF_OFS_A_LSB +: BFF_CNT_W];
            offsets.ae_b <= reg_wdata_in[BFF_OFS_B_LSB +: BFF_CNT_W];
        end else if (reg_write_in && reg_addr_in == BFF_REG_OFFSET_AF) begin
            offsets.af_a <= reg_wdata_in[BFF_OFS_A_LSB +: BFF_CNT_W];
            offsets.af_b <= reg_wdata_in[BFF_OFS_B_LSB +: BFF_CNT_W];
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            mask <= BFF_MASK_RESET;
        end else if (reg_write_in && reg_addr_in == BFF_REG_MASK) begin
            mask <= reg_wdata_in[BFF_EV_N-1:0];
        end
    end

    // New events win over the read that clears
    assign status_clear = reg_read_in && reg_addr_in == BFF_REG_STATUS;

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            status <= '0;
        end else begin
            status <= (status & ~{BFF_EV_N{status_clear}}) | events;
        end
    end

    assign irq_out = |(status & mask);

    // Read data stands only in the cycle after the strobe
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            reg_rdata_out <= '0;
        end else if (reg_read_in) begin
            case (reg_addr_in)
                BFF_REG_CONFIG:    reg_rdata_out <= 32'({cfg_loaded, mode_b});
                BFF_REG_OFFSET_AE: reg_rdata_out <= {7'h00, offsets.ae_b, 7'h00, offsets.ae_a};
                BFF_REG_OFFSET_AF: reg_rdata_out <= {7'h00, offsets.af_b, 7'h00, offsets.af_a};
                BFF_REG_STATUS:    reg_rdata_out <= 32'(status);
                BFF_REG_MASK:      reg_rdata_out <= 32'(mask);
                BFF_REG_COUNT:     reg_rdata_out <= {7'h00, ba_count, 7'h00, ab_count};
                default:           reg_rdata_out <= '0;
            endcase
        end else begin
            reg_rdata_out <= '0;
        end
    end
endmodule
`default_nettype wire

// [verification/bff_top_properties.sv]
// Port-level assertions for the bidirectional FIFO block
`default_nettype none
module bff_top_check (
    input wire logic        clk_in,
    input wire logic        rst_in,
    input wire logic        endian_timing_select_in,
    input wire logic        port_a_write_in,
    input wire logic        port_b_write_in,
    input wire logic        port_b_read_in,
    input wire logic        port_b_valid_out,
    input wire logic        port_a_almost_empty_flag_n_out,
    input wire logic        port_b_almost_empty_flag_n_out,
    input wire logic        port_a_almost_full_flag_n_out,
    input wire logic [4:0]  reg_addr_in,
    input wire logic        reg_read_in,
    input wire logic [31:0] reg_rdata_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (rst_in);
    rdata_idle_a: assert property (!reg_read_in |=> reg_rdata_out == 32'h0) else $error("stale read data");
    b_empty_rise_a: assert property ($rose(port_b_almost_empty_flag_n_out) |->
        $past(port_a_write_in, 3)) else $error("port b almost-empty rose without write");
    a_empty_rise_a: assert property ($rose(port_a_almost_empty_flag_n_out) |->
        $past(port_b_write_in, 3)) else $error("port a almost-empty rose without write");
    a_full_fall_a: assert property ($fell(port_a_almost_full_flag_n_out) |->
        $past(port_a_write_in, 3)) else $error("port a almost-full fell without write");
    a_full_rise_a: assert property ($rose(port_a_almost_full_flag_n_out) |->
        !$past(port_a_write_in, 3)) else $error("port a almost-full rose after write");
    fall_through_a: assert property (!endian_timing_select_in && port_a_write_in && !port_b_valid_out
        |-> ##[1:3] port_b_valid_out) else $error("first word did not fall through");
    std_valid_a: assert property (endian_timing_select_in && $rose(port_b_valid_out) |->
        $past(port_b_read_in)) else $error("standard mode data without read");
    mode_bit_a: assert property (reg_read_in && reg_addr_in == 5'h00 |=>
        reg_rdata_out[2] == $past(endian_timing_select_in)) else $error("mode bit wrong");
    cover property ($fell(port_a_almost_full_flag_n_out));
    cover property ($rose(port_b_valid_out));
    cover property ($rose(port_a_almost_empty_flag_n_out));
endmodule
bind bff_top bff_top_check chk_u (.*);
`default_nettype wire

// [verification/bff_far_b.sv]
// Port B reader: drains shown pieces with a slow read strobe
`default_nettype none
module bff_far_b (
    input  wire logic        clk_in,
    input  wire logic        rst_in,
    input  wire logic        en_in,
    input  wire logic        valid_in,
    input  wire logic [35:0] data_in,
    output logic             read_out,
    output logic             oe_out,
    output logic             got_out,
    output logic [35:0]      word_out
);
    assign oe_out = en_in;
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            read_out <= '0;
            got_out  <= '0;
            word_out <= '0;
        end else begin
            // Gap after each take so the next piece has settled
            read_out <= en_in && valid_in && !read_out && !got_out;
            got_out  <= read_out && valid_in;
            if (read_out && valid_in) word_out <= data_in;
        end
    end
endmodule
`default_nettype wire

// [verification/tb.sv]
// Self-checking bench for the bidirectional FIFO block
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    import bff_pkg::*;
    logic clk_in = '0, rst_in = '1, endian_timing_select_in = '1, port_b_bus_match_select_in = '1;
    logic port_b_size_select_in = '0, port_a_write_in = '0, port_a_read_in = '0, port_b_write_in = '0;
    logic tb_b_read = '0, drain = '0, reg_write_in = '0, reg_read_in = '0, port_b_read_in, far_read, got;
    logic port_a_valid_out, port_b_valid_out, irq_out, port_b_output_enable_in, a_oe, b_oe;
    logic port_a_almost_empty_flag_n_out, port_b_almost_empty_flag_n_out;
    logic port_a_almost_full_flag_n_out, port_b_almost_full_flag_n_out;
    logic [35:0] port_a_data_bus_in = '0, port_b_data_bus_in = '0, port_a_data_bus_out, port_b_data_bus_out, seen;
    logic [35:0] w = 36'h9abcd1234;
    logic [4:0]  reg_addr_in = '0;
    logic [1:0]  fs = '0;
    logic [31:0] reg_wdata_in = '0, reg_rdata_out;
    logic [35:0] flags;
    int          miscompares = 0, compares = 0;
    assign port_b_read_in = far_read | tb_b_read;
    assign flags = {32'h0, port_b_almost_full_flag_n_out, port_a_almost_full_flag_n_out,
                    port_b_almost_empty_flag_n_out, port_a_almost_empty_flag_n_out};
    bff_top dut_u (.*, .flag_offset_select_0_in(fs[0]), .flag_offset_select_1_in(fs[1]),
        .port_a_output_enable_in(1'h1), .port_a_data_bus_oe_out(a_oe), .port_b_data_bus_oe_out(b_oe));
    bff_far_b far_u (.clk_in, .rst_in, .en_in(drain), .valid_in(port_b_valid_out), .data_in(port_b_data_bus_out),
        .read_out(far_read), .oe_out(port_b_output_enable_in), .got_out(got), .word_out(seen));
    initial forever #20 clk_in = ~clk_in;
    task automatic chk(input string n, input logic [35:0] e, input logic [35:0] g);
        compares++;
        if (g !== e) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic print_verdict;
        if (miscompares == 0 && compares > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic restart(input logic sel, input logic bmatch, input logic size, input logic [1:0] fsel);
        @(posedge clk_in) {rst_in, drain, endian_timing_select_in} <= {2'h2, sel};
        {port_b_bus_match_select_in, port_b_size_select_in, fs} <= {bmatch, size, fsel};
        repeat (5) @(posedge clk_in);
        rst_in <= '0;
        repeat (2) @(posedge clk_in);
    endtask
    task automatic wr(input logic b, input logic [35:0] d);
        @(posedge clk_in) {port_b_write_in, port_a_write_in, port_b_data_bus_in, port_a_data_bus_in} <= {b, !b, d, d};
        @(posedge clk_in) {port_a_write_in, port_b_write_in} <= '0;
    endtask
    task automatic rd(input logic b);
        @(posedge clk_in) {tb_b_read, port_a_read_in} <= {b, !b};
        @(posedge clk_in) {tb_b_read, port_a_read_in} <= '0;
        #1;
    endtask
    task automatic reg_op(input logic wen, input logic [4:0] a, input logic [31:0] d);
        @(posedge clk_in) {reg_write_in, reg_read_in, reg_addr_in, reg_wdata_in} <= {wen, !wen, a, d};
        @(posedge clk_in) {reg_write_in, reg_read_in} <= '0;
        #1;
    endtask
    task automatic take(input logic [35:0] e);
        for (int k = 0; k < 20 && !got; k++) @(posedge clk_in) #1;
        chk("port b take", e, seen);
        @(posedge clk_in) #1;
    endtask
    initial begin
        restart('1, '1, '0, 2'h2);
        chk("reset flags", {32'h0, BFF_FLAG_RESET}, flags);
        wr('0, w);
        rd('1);
        chk("port b word", {18'h0, w[35:18]}, port_b_data_bus_out);
        rd('1);
        chk("port b word", {18'h0, w[17:0]}, port_b_data_bus_out);
        wr('1, {18'h0, w[35:18]});
        wr('1, {18'h0, w[17:0]});
        rd('0);
        chk("port a long", w, port_a_data_bus_out);
        chk("a valid oe", 36'h6, {33'h0, port_a_valid_out, a_oe, b_oe});
        reg_op('0, BFF_REG_CONFIG, '0);
        chk("config", 36'h1d, {4'h0, reg_rdata_out});
        reg_op('0, 5'h18, '0);
        chk("unmapped", 36'h0, {4'h0, reg_rdata_out});
        reg_op('0, BFF_REG_OFFSET_AF, '0);
        chk("af offsets", 36'h000400040, {4'h0, reg_rdata_out});
        restart('0, '1, '1, 2'h1);
        reg_op('0, BFF_REG_OFFSET_AE, '0);
        chk("ae offsets", 36'h000100010, {4'h0, reg_rdata_out});
        drain <= '1;
        wr('0, w);
        for (int i = 0; i < 4; i++) take({27'h0, w[9*i +: 9]});
        restart('0, '0, '0, 2'h0);
        for (int i = 0; i < 258; i++) wr('0, 36'(i));
        repeat (4) @(posedge clk_in) #1;
        chk("full flags", 36'ha, flags);
        chk("irq masked", 36'h0, {35'h0, irq_out});
        reg_op('1, BFF_REG_MASK, 32'h1);
        chk("irq raised", 36'h1, {35'h0, irq_out});
        reg_op('0, BFF_REG_STATUS, '0);
        chk("status", 36'h11, {4'h0, reg_rdata_out});
        chk("irq cleared", 36'h0, {35'h0, irq_out});
        for (int i = 0; i < 10; i++) wr('1, 36'(i));
        repeat (4) @(posedge clk_in) #1;
        chk("b fill flags", 36'hb, flags);
        drain <= '1;
        for (int i = 0; i < 256; i++) take(36'(i));
        repeat (4) @(posedge clk_in) #1;
        chk("drained flags", 36'hd, flags);
        print_verdict();
    end
    initial begin
        repeat (6000) @(posedge clk_in);
        miscompares++;
        print_verdict();
    end
endmodule
`default_nettype wire
